// ===== rtl/dual_zone_password_guard.sv
/*
 * Two-zone password guard: per-zone lock and emulation guard, access
 * filtering for fetch, read, write and debug, debug register masking.
 * Assumes the CPU reports owner zone of each access and of the PC, and
 * that password reads arrive from the settings area on the same clock.
 */
// Summary of operation
// - Locked zone memory is hidden from debug, external code and loaders.
// - A zone unlocks when the written 128-bit key equals its password.
// - An all-ones password unlocks the zone on dummy read, key ignored.
// - Halting in secure code trips the guard and cuts the debug link.
// - Matching the lower 64 key bits disarms the guard; reads stay blocked.
// - An all-zero lower password half disarms the guard on dummy read.
// - Debug register reads other than the PC show zero while running locked code.
// - Instruction fetch from the security settings area is refused.
// - No hardware wait-in-reset mode exists for debugger attach.
// - One locked zone's memory is denied to the other zone's code for reads and writes; fetches are granted.
// - Execute-only memory denies reads and writes, allows fetch only.
`timescale 1ns/1ps
`default_nettype none
module dual_zone_password_guard #(
    parameter int DATA_W = zone_guard_pkg::WORD_BITS
) (
    input  wire logic                                  clock_i,
    input  wire logic                                  resetn_i,
    // Key register writes
    input  wire logic                                  key_we_i,
    input  wire logic                                  key_zone_i,
    input  wire logic [zone_guard_pkg::WORD_IDX_W-1:0] key_idx_i,
    input  wire logic [zone_guard_pkg::WORD_BITS-1:0]  key_data_i,
    // Dummy reads of the password words
    input  wire logic                                  pwd_rd_i,
    input  wire logic                                  pwd_zone_i,
    input  wire logic [zone_guard_pkg::WORD_IDX_W-1:0] pwd_idx_i,
    input  wire logic [zone_guard_pkg::WORD_BITS-1:0]  pwd_data_i,
    // Memory access check
    input  wire logic                                  acc_valid_i,
    input  wire logic [1:0]                            acc_kind_i,
    input  wire logic [1:0]                            acc_owner_i,
    input  wire logic                                  acc_exec_only_i,
    input  wire logic                                  acc_settings_i,
    input  wire logic [1:0]                            code_owner_i,
    input  wire logic                                  code_external_i,
    output logic                                       acc_grant_o,
    output logic                                       acc_deny_o,
    // Debug
    input  wire logic                                  cpu_halted_i,
    input  wire logic [1:0]                            pc_owner_i,
    input  wire logic                                  dbg_rd_i,
    input  wire logic                                  dbg_rd_pc_i,
    input  wire logic [DATA_W-1:0]                     dbg_rd_data_i,
    output logic [DATA_W-1:0]                          dbg_rd_data_o,
    output logic                                       debug_cut_o,
    output logic                                       zone_one_locked_o,
    output logic                                       zone_two_locked_o,
    output logic                                       zone_one_guard_o,
    output logic                                       zone_two_guard_o
);
    logic [zone_guard_pkg::ZONE_COUNT-1:0] locked;
    logic [zone_guard_pkg::ZONE_COUNT-1:0] armed;
    logic                                  owner_locked;
    logic                                  code_locked;
    logic                                  pc_armed;
    logic                                  same_zone;
    logic                                  next_deny;
    logic                                  sync_a;
    logic                                  sync_b;
    logic                                  sync_c;

    // One unit per zone
    genvar z;
    generate
        for (z = 0; z < zone_guard_pkg::ZONE_COUNT; z++) begin : g_zone
            zone_unit u_zone (
                .clock_i       (clock_i),
                .resetn_i      (resetn_i),
                .key_we_i      (key_we_i && (key_zone_i == 1'(z))),
                .key_idx_i     (key_idx_i),
                .key_data_i    (key_data_i),
                .pwd_rd_i      (pwd_rd_i && (pwd_zone_i == 1'(z))),
                .pwd_idx_i     (pwd_idx_i),
                .pwd_data_i    (pwd_data_i),
                .locked_o      (locked[z]),
                .guard_armed_o (armed[z])
            );
        end
    endgenerate

    assign zone_one_locked_o = locked[0];
    assign zone_two_locked_o = locked[1];
    assign zone_one_guard_o  = armed[0];
    assign zone_two_guard_o  = armed[1];

    // Lock state of the zone owning the access and of the running code
    always_comb begin
        owner_locked = 1'b0;
        code_locked  = 1'b0;
        pc_armed     = 1'b0;
        case (acc_owner_i)
            zone_guard_pkg::OWNER_ONE: owner_locked = locked[0];
            zone_guard_pkg::OWNER_TWO: owner_locked = locked[1];
            default:                   owner_locked = 1'b0;
        endcase
        case (code_owner_i)
            zone_guard_pkg::OWNER_ONE: code_locked = locked[0];
            zone_guard_pkg::OWNER_TWO: code_locked = locked[1];
            default:                   code_locked = 1'b0;
        endcase
        case (pc_owner_i)
            zone_guard_pkg::OWNER_ONE: pc_armed = armed[0];
            zone_guard_pkg::OWNER_TWO: pc_armed = armed[1];
            default:                   pc_armed = 1'b0;
        endcase
    end

    assign same_zone = (acc_owner_i == code_owner_i);

    // Access decision
    always_comb begin
        next_deny = 1'b0;
        case (zone_guard_pkg::access_e'(acc_kind_i))
            zone_guard_pkg::ACC_FETCH: begin
                next_deny = acc_settings_i
                         || (owner_locked && code_external_i);
            end
            zone_guard_pkg::ACC_READ,
            zone_guard_pkg::ACC_WRITE: begin
                next_deny = acc_exec_only_i
                         || (owner_locked && !same_zone)
                         || (owner_locked && code_external_i);
            end
            zone_guard_pkg::ACC_DEBUG: begin
                next_deny = owner_locked || acc_exec_only_i;
            end
            default: next_deny = 1'b1;
        endcase
    end

    // Registered grant and deny
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_grant_o <= 1'b0;
            acc_deny_o  <= 1'b0;
        end else begin
            acc_grant_o <= acc_valid_i && !next_deny;
            acc_deny_o  <= acc_valid_i && next_deny;
        end
    end

    // Halt pin from the debug side: three-stage synchroniser
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            sync_c <= 1'b0;
        end else begin
            sync_a <= cpu_halted_i;
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // Guard trip: sticky until reset; no wait-in-reset bypass exists
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            debug_cut_o <= 1'b0;
        end else if (sync_b && sync_c && pc_armed) begin
            debug_cut_o <= 1'b1;
        end
    end

    // Debug register read masking while locked code runs
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dbg_rd_data_o <= '0;
        end else if (dbg_rd_i) begin
            if ((code_locked || debug_cut_o) && !dbg_rd_pc_i) begin
                dbg_rd_data_o <= '0;
            end else begin
                dbg_rd_data_o <= dbg_rd_data_i;
            end
        end
    end
endmodule : dual_zone_password_guard
`default_nettype wire

// ===== rtl/zone_guard_pkg.sv
/*
 * Constants shared by the two-zone password guard and its zone unit.
 * Assumes a single system clock and an active-low asynchronous reset.
 */
package zone_guard_pkg;
    localparam int KEY_BITS    = 128;
    localparam int HALF_BITS   = 64;
    localparam int WORD_BITS   = 32;
    localparam int WORD_COUNT  = 4;
    localparam int WORD_IDX_W  = 2;
    localparam int ZONE_COUNT  = 2;
    localparam logic [WORD_COUNT-1:0] ALL_WORDS_SEEN = 4'hF;
    localparam logic [WORD_COUNT-1:0] NO_WORDS_SEEN  = 4'h0;
    localparam logic [WORD_BITS-1:0]  WORD_ERASED    = 32'hFFFFFFFF;
    localparam logic [WORD_BITS-1:0]  WORD_ZERO      = 32'h00000000;
    // Reset state of every zone: locked, emulation guard armed
    localparam logic LOCKED_AT_RESET = 1'b1;
    localparam logic GUARD_AT_RESET  = 1'b1;
    // Zone owner codes on the access ports
    localparam logic [1:0] OWNER_NONE = 2'h0;
    localparam logic [1:0] OWNER_ONE  = 2'h1;
    localparam logic [1:0] OWNER_TWO  = 2'h2;
    typedef enum logic [1:0] {
        ACC_FETCH,
        ACC_READ,
        ACC_WRITE,
        ACC_DEBUG
    } access_e;
endpackage : zone_guard_pkg

// ===== rtl/zone_unit.sv
/*
 * One security zone: password capture from dummy reads, key compare,
 * lock state and emulation guard state.
 * Assumes key and password strobes come from same-clock logic.
 */
`timescale 1ns/1ps
`default_nettype none
module zone_unit (
    input  wire logic                                  clock_i,
    input  wire logic                                  resetn_i,
    input  wire logic                                  key_we_i,
    input  wire logic [zone_guard_pkg::WORD_IDX_W-1:0] key_idx_i,
    input  wire logic [zone_guard_pkg::WORD_BITS-1:0]  key_data_i,
    input  wire logic                                  pwd_rd_i,
    input  wire logic [zone_guard_pkg::WORD_IDX_W-1:0] pwd_idx_i,
    input  wire logic [zone_guard_pkg::WORD_BITS-1:0]  pwd_data_i,
    output logic                                       locked_o,
    output logic                                       guard_armed_o
);
    logic [zone_guard_pkg::KEY_BITS-1:0]   key;
    logic [zone_guard_pkg::KEY_BITS-1:0]   pwd;
    logic [zone_guard_pkg::WORD_COUNT-1:0] seen;
    logic                                  all_seen;
    logic                                  full_match;
    logic                                  half_match;
    logic                                  pwd_erased;
    logic                                  low_zero;

    // Key words written by software
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            key <= '0;
        end else if (key_we_i) begin
            key[key_idx_i*zone_guard_pkg::WORD_BITS +:
                zone_guard_pkg::WORD_BITS] <= key_data_i;
        end
    end

    // Password captured from the latest dummy reads
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pwd  <= '0;
            seen <= zone_guard_pkg::NO_WORDS_SEEN;
        end else if (pwd_rd_i) begin
            pwd[pwd_idx_i*zone_guard_pkg::WORD_BITS +:
                zone_guard_pkg::WORD_BITS] <= pwd_data_i;
            seen[pwd_idx_i] <= 1'b1;
        end
    end

    assign all_seen   = (seen == zone_guard_pkg::ALL_WORDS_SEEN);
    assign full_match = (key == pwd);
    assign half_match = (key[zone_guard_pkg::HALF_BITS-1:0]
                         == pwd[zone_guard_pkg::HALF_BITS-1:0]);
    assign pwd_erased = (&pwd);
    assign low_zero   = ~(|pwd[zone_guard_pkg::HALF_BITS-1:0]);

    // Lock state: any strobe relocks, then the compare decides each cycle,
    // so a wrong key written over a good one leaves it locked unless the password is all ones
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            locked_o <= zone_guard_pkg::LOCKED_AT_RESET;
        end else if (key_we_i || pwd_rd_i) begin
            locked_o <= zone_guard_pkg::LOCKED_AT_RESET;
        end else begin
            locked_o <= !(all_seen && (pwd_erased || full_match));
        end
    end

    // Emulation guard: disarmed by half key or all-zero low half
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            guard_armed_o <= zone_guard_pkg::GUARD_AT_RESET;
        end else if (key_we_i || pwd_rd_i) begin
            guard_armed_o <= zone_guard_pkg::GUARD_AT_RESET;
        end else begin
            guard_armed_o <= !(all_seen
                               && (pwd_erased || half_match || low_zero));
        end
    end
endmodule : zone_unit
`default_nettype wire

// ===== sim/dual_zone_password_guard_tb.sv
/* Bench for the two-zone password guard.
   Assumes the settings area model answers the password reads. */
`timescale 1ns/1ps
`default_nettype none
module dual_zone_password_guard_tb;
    localparam logic [127:0] KEY_ONE = 128'h0123456789ABCDEF_FEDCBA9876543210;
    localparam logic [31:0]  REG_VAL = 32'hA5A5C3C3;
    logic        clock_i, resetn_i, key_we_i, key_zone_i, pwd_rd_i, pwd_zone_i;
    logic        acc_valid_i, acc_exec_only_i, acc_settings_i, code_external_i;
    logic        cpu_halted_i, dbg_rd_i, dbg_rd_pc_i, acc_grant_o, acc_deny_o;
    logic        debug_cut_o, zone_one_locked_o, zone_two_locked_o;
    logic        zone_one_guard_o, zone_two_guard_o;
    logic [1:0]  key_idx_i, pwd_idx_i, acc_kind_i, acc_owner_i;
    logic [1:0]  code_owner_i, pc_owner_i;
    logic [31:0] key_data_i, pwd_data_i, dbg_rd_data_i, dbg_rd_data_o;
    int          miscompares = 0;
    int          checks_done = 0;
    dual_zone_password_guard dual_zone_password_guard_inst (.*);
    settings_area_model settings_area_model_inst (.zone_i(pwd_zone_i),
        .idx_i(pwd_idx_i), .word_o(pwd_data_i));
    // System clock, 20 ns period
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task automatic check(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task automatic zone_state(input logic l1, g1, l2, g2);
        check("zone_one_locked_o", l1, zone_one_locked_o);
        check("zone_one_guard_o", g1, zone_one_guard_o);
        check("zone_two_locked_o", l2, zone_two_locked_o);
        check("zone_two_guard_o", g2, zone_two_guard_o);
    endtask : zone_state
    // Key words first, then dummy reads of all four password words
    task automatic load(input logic zone, input logic [127:0] key);
        for (int i = 0; i < 9; i++) begin
            @(posedge clock_i);
            {key_we_i, pwd_rd_i} <= {i < 4, i inside {[4:7]}};
            {key_zone_i, pwd_zone_i} <= {zone, zone};
            {key_idx_i, pwd_idx_i} <= {2'(i), 2'(i)};
            key_data_i <= key[(i%4)*32 +: 32];
        end
        repeat (2) @(posedge clock_i);
    endtask : load
    task automatic access(input logic [1:0] kind, owner, code,
                          input logic eo, st, ext, deny);
        @(posedge clock_i);
        {acc_valid_i, acc_kind_i, acc_owner_i, code_owner_i} <=
            {1'b1, kind, owner, code};
        {acc_exec_only_i, acc_settings_i, code_external_i} <= {eo, st, ext};
        @(posedge clock_i);
        acc_valid_i <= 1'b0;
        #1 check("acc_deny_o", deny, acc_deny_o);
        check("acc_grant_o", !deny, acc_grant_o);
    endtask : access
    task automatic dbg(input logic [1:0] owner, input logic pc,
                       input logic [31:0] e);
        @(posedge clock_i);
        {dbg_rd_i, dbg_rd_pc_i, dbg_rd_data_i} <= {1'b1, pc, REG_VAL};
        {pc_owner_i, code_owner_i} <= {owner, owner};
        @(posedge clock_i);
        dbg_rd_i <= 1'b0;
        #1 check("dbg_rd_data_o", e, dbg_rd_data_o);
    endtask : dbg
    task automatic locked_access();
        access(2'h3, 2'h1, 2'h0, 0, 0, 0, 1);
        access(2'h0, 2'h0, 2'h1, 0, 1, 0, 1);
        access(2'h1, 2'h1, 2'h1, 1, 0, 0, 1);
        access(2'h2, 2'h2, 2'h1, 0, 0, 0, 1);
        access(2'h1, 2'h1, 2'h1, 0, 0, 1, 1);
        access(2'h0, 2'h1, 2'h0, 0, 0, 1, 1);
        access(2'h0, 2'h1, 2'h1, 0, 0, 0, 0);
    endtask : locked_access
    task automatic key_cases();
        load(1'b0, {~KEY_ONE[127:64], KEY_ONE[63:0]});
        #1 zone_state(1, 0, 1, 1);
        access(2'h3, 2'h1, 2'h0, 0, 0, 0, 1);
        load(1'b0, KEY_ONE);
        #1 zone_state(0, 0, 1, 1);
        access(2'h3, 2'h1, 2'h0, 0, 0, 0, 0);
        load(1'b1, ~KEY_ONE);
        #1 zone_state(0, 0, 0, 0);
        load(1'b0, ~KEY_ONE);
        #1 zone_state(1, 1, 0, 0);
    endtask : key_cases
    task automatic debug_cases();
        dbg(2'h1, 1'b0, 32'h00000000);
        dbg(2'h1, 1'b1, REG_VAL);
        dbg(2'h2, 1'b0, REG_VAL);
        @(posedge clock_i);
        cpu_halted_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        #1 check("debug_cut_o", 0, debug_cut_o);
        @(posedge clock_i);
        pc_owner_i <= 2'h1;
        repeat (6) @(posedge clock_i);
        #1 check("debug_cut_o", 1, debug_cut_o);
        // Mid-run reset with halt still high: cut clears, then trips again
        @(posedge clock_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        #1 zone_state(1, 1, 1, 1);
        check("debug_cut_o", 0, debug_cut_o);
        repeat (6) @(posedge clock_i);
        #1 check("debug_cut_o", 1, debug_cut_o);
    endtask : debug_cases
    // Reset, then the scenarios in turn
    initial begin
        {resetn_i, key_we_i, key_zone_i, key_idx_i, key_data_i, pwd_rd_i,
         pwd_zone_i, pwd_idx_i, acc_valid_i, acc_kind_i, acc_owner_i,
         acc_exec_only_i, acc_settings_i, code_owner_i, code_external_i,
         cpu_halted_i, pc_owner_i, dbg_rd_i, dbg_rd_pc_i, dbg_rd_data_i} = '0;
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        #1 zone_state(1, 1, 1, 1);
        locked_access();
        key_cases();
        debug_cases();
        stop_test();
    end
    // Limit on run length against a hung sequence
    initial begin
        repeat (3000) @(posedge clock_i);
        miscompares++;
        $display("[FAIL] run length expected below 3000 seen 3000");
        stop_test();
    end
endmodule : dual_zone_password_guard_tb
bind dual_zone_password_guard zone_guard_checker zone_guard_checker_inst (.*);
`default_nettype wire

// ===== sim/settings_area_model.sv
/* Settings area model: returns the password word picked by zone and index.
   Assumes reads are combinational on the bench-driven zone and index. */
`timescale 1ns/1ps
`default_nettype none
module settings_area_model (
    input  wire logic        zone_i,
    input  wire logic [1:0]  idx_i,
    output logic      [31:0] word_o
);
    // Zone one holds a programmed, non-zero password
    localparam logic [127:0] PWD_ONE =
        128'h0123456789ABCDEF_FEDCBA9876543210;
    // Zone two is left erased; nothing here writes CPU registers
    localparam logic [127:0] PWD_TWO = {128{1'b1}};
    // Word lookup, index 0 lowest
    always_comb begin
        word_o = zone_i ? PWD_TWO[idx_i*32 +: 32] : PWD_ONE[idx_i*32 +: 32];
    end
endmodule : settings_area_model
`default_nettype wire

// ===== sim/zone_guard_checker.sv
/* Assertion checker for the two-zone password guard.
   Sees only the guard's ports; bound from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module zone_guard_checker (
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic       key_we_i,
    input wire logic       key_zone_i,
    input wire logic       acc_valid_i,
    input wire logic [1:0] acc_kind_i,
    input wire logic [1:0] acc_owner_i,
    input wire logic       acc_exec_only_i,
    input wire logic       acc_settings_i,
    input wire logic       acc_grant_o,
    input wire logic       acc_deny_o,
    input wire logic       cpu_halted_i,
    input wire logic [1:0] pc_owner_i,
    input wire logic       debug_cut_o,
    input wire logic       zone_one_locked_o,
    input wire logic       zone_two_locked_o,
    input wire logic       zone_one_guard_o,
    input wire logic       zone_two_guard_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    // Lock, guard, access and debug-cut relations
    property p_reset_state; $rose(resetn_i) |-> zone_one_locked_o &&
        zone_two_locked_o && zone_one_guard_o && zone_two_guard_o; endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("zones not locked and armed after reset");
    property p_one_answer; acc_valid_i |=> acc_grant_o != acc_deny_o;
    endproperty
    a_one_answer: assert property (p_one_answer)
        else $error("access not answered exactly once");
    property p_settings; acc_valid_i && acc_kind_i == 2'h0 && acc_settings_i
        |=> acc_deny_o; endproperty
    a_settings: assert property (p_settings)
        else $error("fetch from settings area granted");
    property p_exec_only; acc_valid_i && acc_kind_i inside {2'h1, 2'h2} &&
        acc_exec_only_i |=> acc_deny_o; endproperty
    a_exec_only: assert property (p_exec_only)
        else $error("data access to execute-only memory granted");
    property p_dbg_locked; acc_valid_i && acc_kind_i == 2'h3 &&
        acc_owner_i == 2'h1 && zone_one_locked_o |=> acc_deny_o; endproperty
    a_dbg_locked: assert property (p_dbg_locked)
        else $error("debug read of locked zone granted");
    property p_cut_hold; debug_cut_o |=> debug_cut_o; endproperty
    a_cut_hold: assert property (p_cut_hold)
        else $error("debug cut released before reset");
    property p_halt_cut; (resetn_i && cpu_halted_i && pc_owner_i == 2'h1 &&
        zone_one_guard_o) [*4] |=> debug_cut_o; endproperty
    a_halt_cut: assert property (p_halt_cut)
        else $error("halt in armed zone did not cut debug");
    property p_key_relock; key_we_i && !key_zone_i
        |=> zone_one_locked_o && zone_one_guard_o; endproperty
    a_key_relock: assert property (p_key_relock)
        else $error("key write did not relock zone one");
endmodule : zone_guard_checker
`default_nettype wire
